// >>> verilog/csw_regs.svh
// Purpose: register map, field positions, reset values and timing counts
// Assumes: byte-wide register port with a 12-bit address
// Notes: serial_main_ctrl and word_count_wait_ctrl are write-only
`ifndef CSW_REGS_SVH
`define CSW_REGS_SVH

// register addresses
`define CSW_ADDR_MAIN 12'h028
`define CSW_ADDR_WCW 12'h029
`define CSW_ADDR_STAT 12'h029
`define CSW_ADDR_OPT 12'h02A
`define CSW_ADDR_BUF 12'hF90
`define CSW_ADDR_BUF_TOP 9'h1F2

// serial_main_ctrl fields
`define CSW_MAIN_START 7
`define CSW_MAIN_ABORT 6
`define CSW_MAIN_MODE_LSB 3
`define CSW_MAIN_CKSEL_LSB 0
`define CSW_MAIN_RST 8'h00

// word_count_wait_ctrl fields
`define CSW_WCW_WAIT_LSB 3
`define CSW_WCW_COUNT_LSB 0
`define CSW_WCW_RST 5'h00

// clock option register fields
`define CSW_OPT_STAGE_A 0
`define CSW_OPT_STAGE_B 1
`define CSW_OPT_LOW_FREQ 2
`define CSW_OPT_RST 3'h0

// status fields
`define CSW_STAT_TIP 7
`define CSW_STAT_SHIFT 6

// transfer modes and clock codes
`define CSW_MODE_TX8 3'h0
`define CSW_MODE_TX4 3'h2
`define CSW_MODE_TRX8 3'h4
`define CSW_MODE_RX8 3'h5
`define CSW_MODE_RX4 3'h6
`define CSW_CKSEL_RSVD 3'h6
`define CSW_CKSEL_EXT 3'h7

// timing
`define CSW_SYS_CLK_HZ 200000000
`define CSW_FS_HZ 32768
`define CSW_FS_DIV (`CSW_SYS_CLK_HZ / `CSW_FS_HZ)
`define CSW_FS_HALF 16

`endif

// >>> verilog/csw_pkg.sv
// Purpose: types shared by the serial word buffer control block
// Assumes: constants come from csw_regs.svh
// Notes: state codes are one-hot
package csw_pkg;

   // engine phases
   typedef enum logic [3:0] {
      CSW_IDLE = 4'h1,
      CSW_SHIFT = 4'h2,
      CSW_GAP = 4'h4,
      CSW_STALL = 4'h8
   } csw_phase_type;

   // register port request
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } csw_bus_req_type;

   // serial pin drives
   typedef struct packed {
      logic sck_out;
      logic sck_oe;
      logic so_out;
      logic so_oe;
   } csw_pin_out_type;

   // rate generator configuration
   typedef struct packed {
      logic [2:0] cksel;
      logic stage_a;
      logic stage_b;
      logic low_freq;
   } csw_clk_cfg_type;

endpackage

// >>> verilog/csw_clkgen.sv
// Purpose: internal serial clock half-period tick generator
// Assumes: sys_clk is the high-frequency clock fc
// Notes: tick is one cycle per half serial clock period while run is high
`timescale 1ns/1ps
`include "csw_regs.svh"
module csw_clkgen #(
   parameter int FS_DIV = `CSW_FS_DIV
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic run,
   input wire csw_pkg::csw_clk_cfg_type cfg,
   output logic tick
);

   // the prescaler is 16 bits wide
   if (FS_DIV < 2 || FS_DIV > 65536) begin : g_chk
      $error("csw_clkgen: FS_DIV must be 2 to 65536");
   end

   typedef struct packed {
      logic [13:0] fc_cnt;
      logic [15:0] fs_pre;
      logic [4:0] fs_cnt;
      logic tick;
   } csw_gen_state_type;

   csw_gen_state_type r_reg;
   csw_gen_state_type r_next;

   // half period in fc cycles, zero when no internal rate applies
   function automatic logic [13:0] csw_half(input csw_pkg::csw_clk_cfg_type c);
      logic [13:0] h;
      h = 14'h0000;
      case (c.cksel)
         3'h0: h = c.stage_b ? 14'h2000 : 14'h1000;
         3'h1: h = c.stage_b ? 14'h0100 : 14'h0080;
         3'h2: h = c.stage_b ? 14'h0080 : 14'h0040;
         3'h3: h = c.stage_b ? 14'h0040 : 14'h0020;
         3'h4: h = c.stage_b ? 14'h0020 : 14'h0010;
         3'h5: h = c.stage_b ? 14'h0010 : 14'h0008;
         default: h = 14'h0000;
      endcase
      return h;
   endfunction

   logic use_fs;
   logic [13:0] half;
   logic fs_tick;

   // rate source choice
   always_comb begin
      use_fs = (cfg.cksel == 3'h0) && (cfg.stage_a || cfg.low_freq);
      half = cfg.low_freq && (cfg.cksel != 3'h0) ? 14'h0000 : csw_half(cfg);
      fs_tick = (r_reg.fs_pre == 16'(FS_DIV - 1));
   end

   // counters
   always_comb begin
      r_next = r_reg;
      r_next.tick = 1'b0;
      r_next.fs_pre = fs_tick ? 16'h0000 : r_reg.fs_pre + 16'h0001;
      if (!run) begin
         r_next.fc_cnt = 14'h0000;
         r_next.fs_cnt = 5'h00;
      end else if (use_fs) begin
         if (fs_tick) begin
            if (r_reg.fs_cnt == 5'(`CSW_FS_HALF - 1)) begin
               r_next.fs_cnt = 5'h00;
               r_next.tick = 1'b1;
            end else begin
               r_next.fs_cnt = r_reg.fs_cnt + 5'h01;
            end
         end
      end else if (half != 14'h0000) begin
         if (r_reg.fc_cnt == half - 14'h0001) begin
            r_next.fc_cnt = 14'h0000;
            r_next.tick = 1'b1;
         end else begin
            r_next.fc_cnt = r_reg.fc_cnt + 14'h0001;
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r_reg <= '0;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   assign tick = r_reg.tick;

endmodule // csw_clkgen

// >>> verilog/csw_ctrl.sv
// Purpose: control, status and buffer sequencing of a clocked serial unit
// Assumes: pin inputs are asynchronous to sys_clk; register port is on sys_clk
// Notes: the data buffer sits at 12'hF90..12'hF97 on the register port
`timescale 1ns/1ps
`include "csw_regs.svh"
module csw_ctrl #(
   parameter int FS_DIV = `CSW_FS_DIV,
   parameter int WORDS = 8
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire csw_pkg::csw_bus_req_type bus_req,
   output logic [7:0] rdata,
   input wire logic sck_in,
   input wire logic si_in,
   output csw_pkg::csw_pin_out_type pins,
   output logic serial_burst_irq
);

   if (WORDS != 8) begin : g_chk
      $error("csw_ctrl: WORDS must be 8, the count field is 3 bits");
   end

   typedef struct packed {
      csw_pkg::csw_phase_type phase;
      logic [7:0] main_ctrl;
      logic [4:0] wcw;
      logic [2:0] opt;
      logic [WORDS-1:0][7:0] data_buf;
      logic [7:0] rdata;
      logic [7:0] shreg;
      logic [3:0] bitcnt;
      logic [2:0] word_idx;
      logic [7:0] gap_cnt;
      logic serviced;
      logic tip;
      logic irq;
      logic sck_lvl;
      logic sck_oe;
      logic so_out;
      logic so_oe;
      logic sck_s1;
      logic sck_s2;
      logic sck_prev;
      logic si_s1;
      logic si_s2;
   } csw_state_type;

   csw_state_type r_reg;
   csw_state_type r_next;

   // buffer address decode, used by both read and write
   function automatic logic csw_is_buf(input logic [11:0] a);
      return a[11:3] == `CSW_ADDR_BUF_TOP;
   endfunction

   logic tick;
   logic run;
   csw_pkg::csw_clk_cfg_type clk_cfg;
   logic [2:0] mode;
   logic [2:0] cksel;
   logic [2:0] count;
   logic [1:0] wait_code;
   logic four_bit;
   logic is_tx;
   logic is_rx;
   logic ext_clk;
   logic fall_ev;
   logic rise_ev;
   logic [3:0] last_bit;
   logic [7:0] shifted;
   logic [7:0] gap_len;
   logic last_word;
   logic [2:0] next_idx;

   // field views of the control registers
   always_comb begin
      mode = r_reg.main_ctrl[`CSW_MAIN_MODE_LSB +: 3];
      cksel = r_reg.main_ctrl[`CSW_MAIN_CKSEL_LSB +: 3];
      count = r_reg.wcw[`CSW_WCW_COUNT_LSB +: 3];
      wait_code = r_reg.wcw[`CSW_WCW_WAIT_LSB +: 2];
      four_bit = (mode == `CSW_MODE_TX4) || (mode == `CSW_MODE_RX4);
      is_tx = (mode == `CSW_MODE_TX8) || (mode == `CSW_MODE_TX4) || (mode == `CSW_MODE_TRX8);
      is_rx = (mode == `CSW_MODE_TRX8) || (mode == `CSW_MODE_RX8) || (mode == `CSW_MODE_RX4);
      ext_clk = (cksel == `CSW_CKSEL_EXT);
      clk_cfg.cksel = cksel;
      clk_cfg.stage_a = r_reg.opt[`CSW_OPT_STAGE_A];
      clk_cfg.stage_b = r_reg.opt[`CSW_OPT_STAGE_B];
      clk_cfg.low_freq = r_reg.opt[`CSW_OPT_LOW_FREQ];
      run = !ext_clk && ((r_reg.phase == csw_pkg::CSW_SHIFT) || (r_reg.phase == csw_pkg::CSW_GAP));
   end

   // serial clock edges, from the rate tick or the synchronised pin
   always_comb begin
      if (ext_clk) begin
         fall_ev = r_reg.sck_prev && !r_reg.sck_s2;
         rise_ev = !r_reg.sck_prev && r_reg.sck_s2;
      end else begin
         fall_ev = tick && r_reg.sck_lvl;
         rise_ev = tick && !r_reg.sck_lvl;
      end
   end

   // word arithmetic
   always_comb begin
      last_bit = four_bit ? 4'h3 : 4'h7;
      if (four_bit) begin
         shifted = {4'h0, r_reg.si_s2, r_reg.shreg[3:1]};
      end else begin
         shifted = {r_reg.si_s2, r_reg.shreg[7:1]};
      end
      // extra half periods: (2^wait - 1) words of bits, two halves a bit
      case (wait_code)
         2'h1: gap_len = four_bit ? 8'h08 : 8'h10;
         2'h2: gap_len = four_bit ? 8'h18 : 8'h30;
         2'h3: gap_len = four_bit ? 8'h38 : 8'h70;
         default: gap_len = 8'h00;
      endcase
      last_word = (r_reg.word_idx == count);
      next_idx = last_word ? 3'h0 : r_reg.word_idx + 3'h1;
   end

   csw_clkgen #(
      .FS_DIV(FS_DIV)
   ) u_clkgen (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .ce(ce),
      .run(run),
      .cfg(clk_cfg),
      .tick(tick)
   );

   // engine first, then register port effects so software wins where it must
   always_comb begin
      r_next = r_reg;
      r_next.irq = 1'b0;
      r_next.rdata = 8'h00;
      r_next.sck_s1 = sck_in;
      r_next.sck_s2 = r_reg.sck_s1;
      r_next.sck_prev = r_reg.sck_s2;
      r_next.si_s1 = si_in;
      r_next.si_s2 = r_reg.si_s1;

      case (r_reg.phase)
         csw_pkg::CSW_IDLE: begin
            r_next.sck_lvl = 1'b1;
         end
         csw_pkg::CSW_SHIFT: begin
            if (tick && !ext_clk) begin
               r_next.sck_lvl = !r_reg.sck_lvl;
            end
            if (fall_ev) begin
               r_next.so_out = r_reg.shreg[0];
            end
            if (rise_ev) begin
               r_next.shreg = shifted;
               r_next.bitcnt = r_reg.bitcnt + 4'h1;
               if (r_reg.bitcnt == last_bit) begin
                  r_next.bitcnt = 4'h0;
                  if (is_rx) begin
                     r_next.data_buf[r_reg.word_idx] = shifted;
                  end
                  r_next.word_idx = next_idx;
                  r_next.shreg = r_reg.data_buf[next_idx];
                  if (last_word) begin
                     r_next.irq = 1'b1;
                     r_next.serviced = 1'b0;
                  end
                  if (!r_reg.main_ctrl[`CSW_MAIN_START]) begin
                     r_next.phase = csw_pkg::CSW_IDLE;
                     r_next.tip = 1'b0;
                     r_next.so_oe = 1'b0;
                  end else if (!ext_clk && last_word) begin
                     r_next.phase = csw_pkg::CSW_STALL;
                  end else if (!ext_clk && gap_len != 8'h00) begin
                     r_next.phase = csw_pkg::CSW_GAP;
                     r_next.gap_cnt = gap_len;
                  end
               end
            end
         end
         csw_pkg::CSW_GAP: begin
            r_next.sck_lvl = 1'b1;
            if (!r_reg.main_ctrl[`CSW_MAIN_START]) begin
               r_next.phase = csw_pkg::CSW_IDLE;
               r_next.tip = 1'b0;
               r_next.so_oe = 1'b0;
            end else if (tick) begin
               r_next.gap_cnt = r_reg.gap_cnt - 8'h01;
               if (r_reg.gap_cnt == 8'h01) begin
                  r_next.phase = csw_pkg::CSW_SHIFT;
               end
            end
         end
         csw_pkg::CSW_STALL: begin
            r_next.sck_lvl = 1'b1;
            if (!r_reg.main_ctrl[`CSW_MAIN_START]) begin
               r_next.phase = csw_pkg::CSW_IDLE;
               r_next.tip = 1'b0;
               r_next.so_oe = 1'b0;
            end else if (r_reg.serviced) begin
               r_next.shreg = r_reg.data_buf[3'h0];
               r_next.phase = gap_len != 8'h00 ? csw_pkg::CSW_GAP : csw_pkg::CSW_SHIFT;
               r_next.gap_cnt = gap_len;
            end
         end
         default: begin
            r_next.phase = csw_pkg::CSW_IDLE;
            r_next.tip = 1'b0;
         end
      endcase

      // register writes
      if (bus_req.wr) begin
         if (bus_req.addr == `CSW_ADDR_MAIN) begin
            r_next.main_ctrl = bus_req.wdata;
            r_next.main_ctrl[`CSW_MAIN_ABORT] = 1'b0;
            r_next.sck_oe = bus_req.wdata[`CSW_MAIN_CKSEL_LSB +: 3] != `CSW_CKSEL_EXT;
            if (bus_req.wdata[`CSW_MAIN_ABORT]) begin
               r_next.phase = csw_pkg::CSW_IDLE;
               r_next.tip = 1'b0;
               r_next.so_oe = 1'b0;
               r_next.sck_lvl = 1'b1;
               r_next.bitcnt = 4'h0;
               r_next.word_idx = 3'h0;
            end else if (bus_req.wdata[`CSW_MAIN_START] && !r_reg.tip) begin
               r_next.phase = csw_pkg::CSW_SHIFT;
               r_next.tip = 1'b1;
               r_next.sck_lvl = 1'b1;
               r_next.bitcnt = 4'h0;
               r_next.word_idx = 3'h0;
               r_next.shreg = r_reg.data_buf[3'h0];
               r_next.serviced = 1'b0;
               r_next.so_oe = 1'b1;
            end
         end else if (bus_req.addr == `CSW_ADDR_WCW) begin
            r_next.wcw = bus_req.wdata[4:0];
         end else if (bus_req.addr == `CSW_ADDR_OPT) begin
            r_next.opt = bus_req.wdata[2:0];
         end else if (csw_is_buf(bus_req.addr)) begin
            r_next.data_buf[bus_req.addr[2:0]] = bus_req.wdata;
            r_next.serviced = 1'b1;
         end
      end

      // register reads, data valid in the following cycle only
      if (bus_req.rd) begin
         if (bus_req.addr == `CSW_ADDR_STAT) begin
            r_next.rdata[`CSW_STAT_TIP] = r_reg.tip;
            r_next.rdata[`CSW_STAT_SHIFT] = r_reg.phase == csw_pkg::CSW_SHIFT;
         end else if (bus_req.addr == `CSW_ADDR_OPT) begin
            r_next.rdata = {5'h00, r_reg.opt};
         end else if (csw_is_buf(bus_req.addr)) begin
            r_next.rdata = r_reg.data_buf[bus_req.addr[2:0]];
            r_next.serviced = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r_reg <= '0;
         r_reg.phase <= csw_pkg::CSW_IDLE;
         r_reg.main_ctrl <= `CSW_MAIN_RST;
         r_reg.wcw <= `CSW_WCW_RST;
         r_reg.opt <= `CSW_OPT_RST;
         r_reg.sck_lvl <= 1'b1;
         r_reg.sck_oe <= 1'b1;
         r_reg.sck_s1 <= 1'b1;
         r_reg.sck_s2 <= 1'b1;
         r_reg.sck_prev <= 1'b1;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   // outputs straight from the state register
   assign rdata = r_reg.rdata;
   assign serial_burst_irq = r_reg.irq;
   assign pins.sck_out = r_reg.sck_lvl;
   assign pins.sck_oe = r_reg.sck_oe;
   assign pins.so_out = r_reg.so_out;
   assign pins.so_oe = r_reg.so_oe;

endmodule // csw_ctrl

// >>> sim/csw_ctrl_asserts.sv
// Purpose: port-level checks of the serial word buffer control block
// Assumes: the data output enable follows the transfer flag
// Notes: bound to every csw_ctrl instance
`timescale 1ns/1ps
`include "csw_regs.svh"
module csw_ctrl_asserts #(
   parameter int FS_DIV = `CSW_FS_DIV,
   parameter int WORDS = 8
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire csw_pkg::csw_bus_req_type bus_req,
   input wire logic [7:0] rdata,
   input wire logic sck_in,
   input wire logic si_in,
   input wire csw_pkg::csw_pin_out_type pins,
   input wire logic serial_burst_irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // register port requests
   sequence s_main_wr;
      bus_req.wr && bus_req.addr == `CSW_ADDR_MAIN;
   endsequence
   sequence s_start_req;
      s_main_wr ##0 (bus_req.wdata[7] && !bus_req.wdata[6] && !pins.so_oe);
   endsequence
   sequence s_stat_rd;
      bus_req.rd && bus_req.addr == `CSW_ADDR_STAT;
   endsequence
   // status and write-only registers
   a_status_tip: assert property (
      s_stat_rd |=> rdata[7] == $past(pins.so_oe) && (rdata[7] || !rdata[6]))
      else $error("status flags disagree with transfer state");
   a_count_hidden: assert property (s_stat_rd |=> rdata[5:0] == 6'h00)
      else $error("count register bits visible on read");
   a_main_wo: assert property (
      bus_req.rd && bus_req.addr == `CSW_ADDR_MAIN |=> rdata == 8'h00)
      else $error("main control readable");
   // clock source, start or abort, and interrupt pulse
   a_sck_oe_sel: assert property (
      s_main_wr |=> pins.sck_oe == ($past(bus_req.wdata[2:0]) != 3'h7))
      else $error("clock pin drive does not follow clock select");
   a_start_run: assert property (s_start_req |=> pins.so_oe && pins.sck_out)
      else $error("start did not begin a transfer with clock high");
   a_abort_stop: assert property (s_main_wr ##0 bus_req.wdata[6] |=> !pins.so_oe)
      else $error("abort did not end the transfer");
   a_irq_pulse: assert property (serial_burst_irq |=> !serial_burst_irq)
      else $error("burst interrupt longer than one cycle");
   // serial clock shape
   a_sck_low_min: assert property (
      $fell(pins.sck_out) |-> (!pins.sck_out || !pins.so_oe) [*8])
      else $error("serial clock low half too short");
   a_sck_high_min: assert property (
      $rose(pins.sck_out) && pins.so_oe |-> pins.sck_out [*8])
      else $error("serial clock high half too short");
   a_sck_idle_high: assert property (
      !pins.so_oe && !$past(pins.so_oe) |-> pins.sck_out)
      else $error("serial clock not high while idle");
endmodule // csw_ctrl_asserts

bind csw_ctrl csw_ctrl_asserts #(.FS_DIV(FS_DIV), .WORDS(WORDS)) u_chk (
   .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .bus_req(bus_req), .rdata(rdata),
   .sck_in(sck_in), .si_in(si_in), .pins(pins), .serial_burst_irq(serial_burst_irq));

// >>> sim/csw_periph.sv
// Purpose: behavioural clocked serial peripheral on the far side
// Assumes: lsb first, data out at clock fall, sampled at clock rise
// Notes: word n sent back is tx_base plus n
`timescale 1ns/1ps
module csw_periph (
   input wire logic sck,
   input wire logic so,
   input wire logic sel,
   input wire logic clr,
   input wire logic [7:0] tx_base,
   input wire logic ext_go,
   input wire logic [3:0] bits,
   output logic si,
   output logic sck_drv,
   output logic sck_drv_oe
);
   logic [7:0] got [0:31];
   time t_word [0:31];
   logic [4:0] got_n = 5'h00;
   logic [2:0] idx = 3'h0;
   logic [7:0] sh = 8'h00;
   logic [7:0] cur;
   initial begin
      si = 1'b0;
      sck_drv = 1'b1;
      sck_drv_oe = 1'b0;
   end
   // next bit out on the falling edge
   always @(negedge sck) begin
      cur = tx_base + 8'(got_n);
      if (sel) si = cur[idx];
   end
   // sample on the rising edge, store each whole word
   always @(posedge sck) begin
      if (sel) begin
         sh = {so, sh[7:1]};
         if (idx == 3'(bits - 4'h1)) begin
            got[got_n] = sh;
            t_word[got_n] = $time;
            got_n = got_n + 5'h01;
            idx = 3'h0;
         end else begin
            idx = idx + 3'h1;
         end
      end
   end
   // deselect realigns and lets the data line wander
   always @(negedge sel) begin
      idx = 3'h0;
      si = ~si;
   end
   always @(posedge clr) got_n = 5'h00;
   // external clock, 80 ns period, released between frames
   always @(posedge ext_go) begin
      #3;
      sck_drv_oe = 1'b1;
      repeat (bits) begin
         sck_drv = 1'b0;
         #40;
         sck_drv = 1'b1;
         #40;
      end
      sck_drv_oe = 1'b0;
   end
endmodule // csw_periph

// >>> sim/tb.sv
// Purpose: self-checking bench for the serial word buffer control block
// Assumes: peripheral model on the serial pins, pull-up on the clock pin
// Notes: prescaler shortened to four cycles
`timescale 1ns/1ps
`include "csw_regs.svh"
module tb;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   csw_pkg::csw_bus_req_type req = '0;
   csw_pkg::csw_pin_out_type pins;
   logic [7:0] rdata;
   logic serial_burst_irq;
   logic sck_pin;
   logic si;
   logic sck_drv;
   logic sck_drv_oe;
   logic clr = 1'b0;
   logic ext_go = 1'b0;
   logic [3:0] bits = 4'h8;
   logic [7:0] tx_base = 8'h00;
   int miscompares = 0;
   int checked = 0;
   always #2.5 sys_clk = ~sys_clk;
   // clock pin level, pulled high when undriven
   assign sck_pin = pins.sck_oe ? pins.sck_out : (sck_drv_oe ? sck_drv : 1'b1);
   csw_ctrl #(.FS_DIV(4), .WORDS(8)) u_dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
      .bus_req(req), .rdata(rdata), .sck_in(sck_pin), .si_in(si), .pins(pins),
      .serial_burst_irq(serial_burst_irq));
   csw_periph u_per (.sck(sck_pin), .so(pins.so_out), .sel(pins.so_oe), .clr(clr),
      .tx_base(tx_base), .ext_go(ext_go), .bits(bits), .si(si), .sck_drv(sck_drv),
      .sck_drv_oe(sck_drv_oe));
   function automatic logic [7:0] pat(input int i);
      return 8'(8'h1D * i + 8'h35);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge sys_clk);
      req.rd <= 1'b0;
      @(negedge sys_clk);
      check(rdata, exp);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (serial_burst_irq !== 1'b1 && n < 4000) begin
         @(negedge sys_clk);
         n++;
      end
      check(serial_burst_irq, 1'b1);
   endtask
   task automatic prep(input logic [7:0] base, input logic [3:0] nb);
      @(posedge sys_clk);
      clr <= 1'b1;
      tx_base <= base;
      bits <= nb;
      @(posedge sys_clk);
      clr <= 1'b0;
   endtask
   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      #150000;
      miscompares++;
      final_report();
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(`CSW_ADDR_STAT, 8'h00);
      rd(`CSW_ADDR_MAIN, 8'h00);
      rd(12'h100, 8'h00);
      // eight-word transmit, automatic wait, resume
      for (int i = 0; i < 8; i++) wr(`CSW_ADDR_BUF + 12'(i), pat(i));
      rd(`CSW_ADDR_BUF + 12'h7, pat(7));
      wr(`CSW_ADDR_WCW, 8'h07);
      wr(`CSW_ADDR_MAIN, 8'h85);
      repeat (20) @(posedge sys_clk);
      rd(`CSW_ADDR_STAT, 8'hC0);
      wait_irq();
      for (int i = 0; i < 8; i++) check(u_per.got[i], pat(i));
      rd(`CSW_ADDR_STAT, 8'h80);
      repeat (100) @(posedge sys_clk);
      check(u_per.got_n, 5'h08);
      wr(`CSW_ADDR_BUF, pat(0));
      wait_irq();
      check(u_per.got_n, 5'h10);
      wr(`CSW_ADDR_MAIN, 8'h45);
      rd(`CSW_ADDR_STAT, 8'h00);
      // combined mode, every wait code
      for (int w = 0; w < 4; w++) begin
         prep(8'h40 + 8'(w), 4'h8);
         wr(`CSW_ADDR_WCW, {3'h0, 2'(w), 3'h1});
         wr(`CSW_ADDR_MAIN, 8'hA5);
         wait_irq();
         rd(`CSW_ADDR_BUF, 8'h40 + 8'(w));
         rd(`CSW_ADDR_BUF + 12'h1, 8'h41 + 8'(w));
         check(32'(u_per.t_word[1] - u_per.t_word[0]), 32'h280 << w);
         wr(`CSW_ADDR_MAIN, 8'h65);
      end
      // four-bit receive on the external clock
      prep(8'hA5, 4'h4);
      wr(`CSW_ADDR_WCW, 8'h00);
      wr(`CSW_ADDR_MAIN, 8'hB7);
      @(negedge sys_clk);
      check(pins.sck_oe, 1'b0);
      @(posedge sys_clk);
      ext_go <= 1'b1;
      wait_irq();
      @(posedge sys_clk);
      ext_go <= 1'b0;
      rd(`CSW_ADDR_BUF, 8'h05);
      wr(`CSW_ADDR_MAIN, 8'h77);
      // reserved rate code gives no clock
      prep(8'h00, 4'h8);
      wr(`CSW_ADDR_MAIN, 8'h86);
      repeat (200) @(negedge sys_clk);
      check(pins.sck_out, 1'b1);
      check(u_per.got_n, 5'h00);
      wr(`CSW_ADDR_MAIN, 8'h46);
      rd(`CSW_ADDR_STAT, 8'h00);
      final_report();
   end
endmodule // tb
